// ===== rtl/sac_pkg.sv
// shared constants for the converter control block
package sac_pkg;
  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_OPTION = 8'h94;
  localparam logic [7:0] IDX_FLAGS = 8'h95;
  localparam logic [7:0] IDX_RES_LOW = 8'haa;
  localparam logic [7:0] IDX_RES_HIGH = 8'hab;
  localparam logic [7:0] IDX_CHAN = 8'hb6;
  localparam logic [7:0] IDX_AUXILIARY_CONTROL_THREE = 8'hef;
  localparam logic [7:0] IDX_AUXILIARY_CONTROL_ONE = 8'hf8;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hc0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hc1;
  localparam int ADDR_W = 10;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DIV_LSB = 2;
  localparam int DONE_BIT = 4;
  localparam int START_BIT = 4;
  localparam int VREF_BIT = 0;
  localparam int RES_LOW_LSB = 4;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] DIV_RST = 2'h0;
  localparam logic [3:0] CHAN_RST = 4'hf;
  localparam logic VREF_RST = 1'b0;
  // ---------------------------------------------------------------
  // channel codes and timing
  // ---------------------------------------------------------------
  localparam logic [3:0] CHAN_BANDGAP = 4'hb;
  localparam logic [3:0] CHAN_QUARTER = 4'hf;
  localparam logic [5:0] CONV_CLKS = 6'h32;
  localparam logic [4:0] DIV_MAX = 5'h1f;
  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sac_pkg

// ===== rtl/sac_clk_div.sv
// converter clock divider, one tick per converter clock period
`timescale 1ns/10ps
`default_nettype none
module sac_clk_div (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [1:0] divSel,
  // converter clock tick
  output logic tick
);
  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } sac_div_t;

  sac_div_t st;
  sac_div_t next_st;
  logic [4:0] last;

  // ---------------------------------------------------------------
  // divide by 32, 16, 8 or 4
  // ---------------------------------------------------------------
  always_comb
  begin
    last = sac_pkg::DIV_MAX >> divSel;
    next_st = st;
    next_st.tick = 1'b0;
    if (!run)
    begin
      next_st.cnt = 5'h0;
    end
    else if (st.cnt >= last)
    begin
      next_st.cnt = 5'h0;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt + 5'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_quiet3;
    !tick [*3];
  endsequence

  a_tick_spacing: assert property (
    @(posedge mclk) disable iff (!rst_b) tick |=> s_quiet3)
    else $error("converter ticks closer than four clocks");
endmodule : sac_clk_div
`default_nettype wire

// ===== rtl/sac_adc_ctrl.sv
// converter control block with its register slave
// Operation
// - writing one to start bit begins conversion; hardware clears it at end
// - end of conversion sets done flag and requests interrupt if enabled
// - done flag cleared by writing zero, or by setting start bit
// - conversion lasts 50 converter clocks before completion is signalled
// - result bits 11-4 to high byte, bits 3-0 to shared byte top
// - divider code 00,01,10,11 divides core clock by 32,16,8,4
// - channel codes 0-10 and 12-14 select the matching pin channels
// - code 1111 selects quarter supply, code 1011 the bandgap reference
// - reference bit zero selects supply, one selects fixed 2.5V
// - software writing zero to start bit clears it
// - flag register writes of zero clear a flag, ones are ignored
`timescale 1ns/10ps
`default_nettype none
module sac_adc_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // axi4-lite write address
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog converter side
  input wire logic [11:0] sarResult,
  output logic convBusy,
  output logic convClkTick,
  output logic [15:0] inputSelect,
  output logic bandgapEnable,
  output logic referenceSelect,
  // interrupt
  output logic irq
);
  typedef struct packed {
    logic awReady;
    logic wReady;
    logic awHave;
    logic wHave;
    logic [7:0] awIdx;
    logic awBad;
    logic [7:0] wData;
    logic wLane;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
    logic [1:0] clkDiv;
    logic [3:0] chan;
    logic vref;
    logic startBit;
    logic doneFlag;
    logic busy;
    logic [5:0] tickCnt;
    logic [7:0] resHigh;
    logic [3:0] resLow;
    logic irqStat;
    logic irqMask;
    logic irq;
    logic [15:0] anaSel;
    logic bandgap;
  } sac_state_t;

  sac_state_t st;
  sac_state_t next_st;
  logic tick;
  logic complete;
  logic wrFire;
  logic rdFire;
  logic startFire;
  logic [7:0] arIdx;
  logic arHit;
  logic [7:0] rdVal;

  sac_clk_div u_div (
    .mclk(mclk),
    .rst_b(rst_b),
    .run(st.busy),
    .divSel(st.clkDiv),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  always_comb
  begin
    arIdx = s_axi_araddr[9:2];
    arHit = (s_axi_araddr[1:0] == 2'h0);
    rdVal = 8'h0;
    case (arIdx)
      sac_pkg::IDX_OPTION: rdVal[sac_pkg::DIV_LSB +: 2] = st.clkDiv;
      sac_pkg::IDX_FLAGS: rdVal[sac_pkg::DONE_BIT] = st.doneFlag;
      sac_pkg::IDX_RES_LOW: rdVal[sac_pkg::RES_LOW_LSB +: 4] = st.resLow;
      sac_pkg::IDX_RES_HIGH: rdVal = st.resHigh;
      sac_pkg::IDX_CHAN: rdVal[3:0] = st.chan;
      sac_pkg::IDX_AUXILIARY_CONTROL_THREE: rdVal[sac_pkg::VREF_BIT] = st.vref;
      sac_pkg::IDX_AUXILIARY_CONTROL_ONE: rdVal[sac_pkg::START_BIT] = st.startBit;
      sac_pkg::IDX_IRQ_STAT: rdVal[0] = st.irqStat;
      sac_pkg::IDX_IRQ_MASK: rdVal[0] = st.irqMask;
      default: arHit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    complete = st.busy && tick && (st.tickCnt == sac_pkg::CONV_CLKS - 6'h1);
    wrFire = st.awHave && st.wHave && !st.bValid;
    rdFire = st.arReady && s_axi_arvalid;
    startFire = 1'b0;
    // address and data are taken in either order
    if (st.awReady && s_axi_awvalid)
    begin
      next_st.awHave = 1'b1;
      next_st.awIdx = s_axi_awaddr[9:2];
      next_st.awBad = (s_axi_awaddr[1:0] != 2'h0);
    end
    if (st.wReady && s_axi_wvalid)
    begin
      next_st.wHave = 1'b1;
      next_st.wData = s_axi_wdata[7:0];
      next_st.wLane = s_axi_wstrb[0];
    end
    if (st.bValid && s_axi_bready)
    begin
      next_st.bValid = 1'b0;
    end
    // conversion timing
    if (st.busy && tick)
    begin
      next_st.tickCnt = st.tickCnt + 6'h1;
    end
    // register writes
    if (wrFire)
    begin
      next_st.awHave = 1'b0;
      next_st.wHave = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp = sac_pkg::RESP_OKAY;
      if (st.awBad)
      begin
        next_st.bResp = sac_pkg::RESP_SLVERR;
      end
      else if (st.wLane)
      begin
        case (st.awIdx)
          sac_pkg::IDX_OPTION:
            next_st.clkDiv = st.wData[sac_pkg::DIV_LSB +: 2];
          sac_pkg::IDX_FLAGS:
          begin
            if (!st.wData[sac_pkg::DONE_BIT])
            begin
              next_st.doneFlag = 1'b0;
            end
          end
          sac_pkg::IDX_CHAN: next_st.chan = st.wData[3:0];
          sac_pkg::IDX_AUXILIARY_CONTROL_THREE: next_st.vref = st.wData[sac_pkg::VREF_BIT];
          sac_pkg::IDX_AUXILIARY_CONTROL_ONE:
          begin
            if (st.wData[sac_pkg::START_BIT])
            begin
              // a start while busy is ignored, no restart mid-way
              if (!st.busy)
              begin
                startFire = 1'b1;
                next_st.startBit = 1'b1;
                next_st.busy = 1'b1;
                next_st.tickCnt = 6'h0;
                next_st.doneFlag = 1'b0;
              end
            end
            else
            begin
              // clearing the bit abandons a conversion under way
              next_st.startBit = 1'b0;
              next_st.busy = 1'b0;
            end
          end
          sac_pkg::IDX_IRQ_MASK: next_st.irqMask = st.wData[0];
          sac_pkg::IDX_IRQ_STAT: next_st.irqStat = st.irqStat;
          sac_pkg::IDX_RES_LOW: next_st.resLow = st.resLow;
          sac_pkg::IDX_RES_HIGH: next_st.resHigh = st.resHigh;
          default: next_st.bResp = sac_pkg::RESP_SLVERR;
        endcase
      end
    end
    // reads, status cleared by reading it
    if (rdFire)
    begin
      next_st.rValid = 1'b1;
      next_st.rData = arHit ? rdVal : 8'h0;
      next_st.rResp = arHit ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
      if (arHit && arIdx == sac_pkg::IDX_IRQ_STAT)
      begin
        next_st.irqStat = 1'b0;
      end
    end
    else if (st.rValid && s_axi_rready)
    begin
      next_st.rValid = 1'b0;
    end
    // completion wins over any clear in the same cycle
    if (complete)
    begin
      next_st.busy = 1'b0;
      next_st.startBit = 1'b0;
      next_st.doneFlag = 1'b1;
      next_st.irqStat = 1'b1;
      next_st.resHigh = sarResult[11:4];
      next_st.resLow = sarResult[3:0];
    end
    next_st.awReady = !next_st.awHave;
    next_st.wReady = !next_st.wHave;
    next_st.arReady = !next_st.rValid;
    next_st.irq = next_st.irqStat && next_st.irqMask;
    next_st.anaSel = 16'h1 << next_st.chan;
    next_st.bandgap = (next_st.chan == sac_pkg::CHAN_BANDGAP);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
      st.awReady <= 1'b1;
      st.wReady <= 1'b1;
      st.arReady <= 1'b1;
      st.clkDiv <= sac_pkg::DIV_RST;
      st.chan <= sac_pkg::CHAN_RST;
      st.vref <= sac_pkg::VREF_RST;
      st.anaSel <= 16'h8000;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = st.awReady;
  assign s_axi_wready = st.wReady;
  assign s_axi_bvalid = st.bValid;
  assign s_axi_bresp = st.bResp;
  assign s_axi_arready = st.arReady;
  assign s_axi_rvalid = st.rValid;
  assign s_axi_rresp = st.rResp;
  assign s_axi_rdata = {24'h0, st.rData};
  assign convBusy = st.busy;
  assign convClkTick = tick;
  assign inputSelect = st.anaSel;
  assign bandgapEnable = st.bandgap;
  assign referenceSelect = st.vref;
  assign irq = st.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence s_finish;
    complete ##1 (st.doneFlag && !st.startBit && !st.busy);
  endsequence

  sequence s_no_end8;
    !complete [*8];
  endsequence

  a_done_on_end: assert property (complete |-> s_finish)
    else $error("end of conversion did not set done and clear start");
  a_irq_level: assert property (
    complete && st.irqMask && !wrFire |=> irq)
    else $error("unmasked completion did not raise interrupt");
  a_start_clears: assert property (
    startFire |=> !st.doneFlag && st.startBit && st.busy)
    else $error("start did not clear done flag");
  // even the fastest divider needs far more than eight clocks
  a_conv_length: assert property ($rose(st.busy) |-> s_no_end8)
    else $error("conversion ended right after its start");
  a_tick_idle: assert property (
    !st.busy && !$past(st.busy) |-> !convClkTick)
    else $error("converter clock ticked while idle");
  a_result_split: assert property (complete |=>
    st.resHigh == $past(sarResult[11:4])
    && st.resLow == $past(sarResult[3:0]))
    else $error("result not split into high byte and low nibble");
  a_result_hold: assert property (!complete |=>
    $stable(st.resHigh) && $stable(st.resLow))
    else $error("result changed without a completion");
  a_mux_decode: assert property (
    inputSelect[st.chan] && $onehot(inputSelect)
    && bandgapEnable == (st.chan == sac_pkg::CHAN_BANDGAP))
    else $error("input selection does not match channel code");
  a_vref_write: assert property (
    wrFire && st.wLane && !st.awBad && st.awIdx == sac_pkg::IDX_AUXILIARY_CONTROL_THREE
    |=> referenceSelect == $past(st.wData[sac_pkg::VREF_BIT]))
    else $error("reference select did not follow the write");
  a_flag_one_ignored: assert property (
    wrFire && st.wLane && !st.awBad && st.awIdx == sac_pkg::IDX_FLAGS
    && st.wData[sac_pkg::DONE_BIT] && !complete |=> $stable(st.doneFlag))
    else $error("writing one changed the done flag");
  a_flag_zero_clears: assert property (
    wrFire && st.wLane && !st.awBad && st.awIdx == sac_pkg::IDX_FLAGS
    && !st.wData[sac_pkg::DONE_BIT] && !complete |=> !st.doneFlag)
    else $error("writing zero did not clear the done flag");
  a_stop_write: assert property (
    wrFire && st.wLane && !st.awBad && st.awIdx == sac_pkg::IDX_AUXILIARY_CONTROL_ONE
    && !st.wData[sac_pkg::START_BIT] |=> !st.startBit && !st.busy)
    else $error("writing zero did not clear start bit");
  a_read_answer: assert property (rdFire |=> s_axi_rvalid)
    else $error("read request got no answer in the next cycle");
endmodule : sac_adc_ctrl
`default_nettype wire

// ===== bench/sac_analog_src.sv
// analog source model feeding the converter result
`timescale 1ns/10ps
`default_nettype none
module sac_analog_src (
  // clock
  input wire logic mclk,
  // converter side
  input wire logic convBusy,
  input wire logic [15:0] inputSelect,
  input wire logic referenceSelect,
  input wire logic [11:0] base,
  // result
  output logic [11:0] sarResult
);
  logic [3:0] chan;
  initial sarResult = 12'h5a5;
  // level seen by the converter depends on the routed source
  always_comb
  begin
    chan = 4'h0;
    for (int i = 0; i < 16; i++)
      if (inputSelect[i]) chan = i[3:0];
  end
  // idle: toggle so a stale value is never mistaken for a result
  always @(posedge mclk)
    if (!convBusy) sarResult <= ~sarResult;
    else sarResult <= base ^ {8'h00, chan} ^ {referenceSelect, 11'h000};
endmodule : sac_analog_src
`default_nettype wire

// ===== bench/tb_sar_adc_control.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb_sar_adc_control;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [9:0] awaddr = 10'h000;
  logic [9:0] araddr = 10'h000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] sarResult;
  logic [11:0] base = 12'h000;
  logic convBusy, convClkTick, bandgapEnable, referenceSelect, irq;
  logic [15:0] inputSelect;
  int mismatches = 0;
  int checks = 0;
  int tickCount = 0;
  int results[$];
  sac_adc_ctrl dut (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .sarResult(sarResult),
    .convBusy(convBusy), .convClkTick(convClkTick),
    .inputSelect(inputSelect), .bandgapEnable(bandgapEnable),
    .referenceSelect(referenceSelect), .irq(irq));
  sac_analog_src src (.mclk(mclk), .convBusy(convBusy),
    .inputSelect(inputSelect), .referenceSelect(referenceSelect),
    .base(base), .sarResult(sarResult));
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  // ticks counted apart, so a fast first tick is never missed
  always @(posedge mclk)
    if (convClkTick) tickCount <= tickCount + 1;
  // ---------------------------------------------------------------
  // compare and bus tasks
  // ---------------------------------------------------------------
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: register %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : chk_pin
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
    input logic [1:0] er = sac_pkg::RESP_OKAY);
    bit aw;
    bit w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge mclk);
      if (awvalid && awready)
      begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (!bvalid);
    chk_pin({14'h0000, bresp}, {14'h0000, er});
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
    input logic [1:0] er = sac_pkg::RESP_OKAY);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    chk_pin({14'h0000, rresp}, {14'h0000, er});
    chk_reg(rdata[7:0], exp);
    chk_pin(rdata[31:16] | {8'h00, rdata[15:8]}, 16'h0000);
  endtask : rd
  task automatic print_verdict;
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // one conversion against the integer model; done is left set
  task automatic convert(input logic [1:0] div, input logic [3:0] ch,
    input bit vr, input bit msk);
    int n;
    int ticks;
    int last;
    int res;
    int t0;
    n = 0;
    ticks = 0;
    last = 0;
    base <= 12'($urandom);
    wr(8'hc1, {7'h00, msk});
    wr(sac_pkg::IDX_OPTION, {4'h0, div, 2'b00});
    wr(sac_pkg::IDX_CHAN, {4'h0, ch});
    wr(sac_pkg::IDX_AUXILIARY_CONTROL_THREE, {7'h00, vr});
    res = int'(base ^ {8'h00, ch} ^ {vr, 11'h000});
    t0 = tickCount;
    wr(sac_pkg::IDX_AUXILIARY_CONTROL_ONE, 8'h10);
    rd(sac_pkg::IDX_FLAGS, 8'h00);
    rd(sac_pkg::IDX_RES_HIGH, 8'(results[$] >> 4));
    while (convBusy)
    begin
      @(posedge mclk);
      n++;
      if (convClkTick)
      begin
        if (ticks > 0) chk_pin(16'(n - last), 16'(32 >> div));
        ticks++;
        last = n;
      end
    end
    results.push_back(res);
    chk_pin(16'(tickCount - t0), 16'd50);
    rd(sac_pkg::IDX_AUXILIARY_CONTROL_ONE, 8'h00);
    rd(sac_pkg::IDX_FLAGS, 8'h10);
    chk_pin({15'h0000, irq}, {15'h0000, msk});
    rd(sac_pkg::IDX_RES_HIGH, 8'(res >> 4));
    rd(sac_pkg::IDX_RES_LOW, {4'(res), 4'h0});
    rd(8'hc0, 8'h01);
    @(posedge mclk);
    chk_pin({15'h0000, irq}, 16'h0000);
  endtask : convert
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h575466c4));
    results.push_back(0);
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    rd(sac_pkg::IDX_CHAN, 8'h0f);
    rd(sac_pkg::IDX_AUXILIARY_CONTROL_ONE, 8'h00);
    rd(sac_pkg::IDX_OPTION, 8'h00);
    rd(sac_pkg::IDX_FLAGS, 8'h00);
    chk_pin(inputSelect, 16'h8000);
    rd(8'h10, 8'h00, sac_pkg::RESP_SLVERR);
    wr(8'h10, 8'h00, sac_pkg::RESP_SLVERR);
    wr(sac_pkg::IDX_RES_HIGH, 8'hff);
    rd(sac_pkg::IDX_RES_HIGH, 8'h00);
    for (int c = 0; c < 16; c++)
    begin
      wr(sac_pkg::IDX_CHAN, 8'(c));
      chk_pin(inputSelect, 16'h0001 << c);
      chk_pin({15'h0000, bandgapEnable}, 16'(c == 11));
    end
    for (int v = 1; v >= 0; v--)
    begin
      wr(sac_pkg::IDX_AUXILIARY_CONTROL_THREE, 8'(v));
      chk_pin({15'h0000, referenceSelect}, 16'(v));
    end
    for (int d = 0; d < 4; d++)
      convert(2'(d), 4'($urandom_range(15, 0)), 1'($urandom), d != 2);
    wr(sac_pkg::IDX_FLAGS, 8'hff);
    rd(sac_pkg::IDX_FLAGS, 8'h10);
    wr(sac_pkg::IDX_FLAGS, 8'hef);
    rd(sac_pkg::IDX_FLAGS, 8'h00);
    wr(sac_pkg::IDX_AUXILIARY_CONTROL_ONE, 8'h10);
    wr(sac_pkg::IDX_AUXILIARY_CONTROL_ONE, 8'h00);
    chk_pin({15'h0000, convBusy}, 16'h0000);
    repeat (250) @(posedge mclk);
    rd(sac_pkg::IDX_AUXILIARY_CONTROL_ONE, 8'h00);
    rd(sac_pkg::IDX_FLAGS, 8'h00);
    wr(sac_pkg::IDX_CHAN, 8'h0f);
    print_verdict;
  end
  // hang guard, well beyond the four conversions
  initial
  begin
    #(5 * 40000);
    mismatches++;
    print_verdict;
  end
endmodule : tb_sar_adc_control
`default_nettype wire
